// >>> rtl/acr_pkg.sv
// Shared constants for the converter chip-select readout block.
package acr_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_MIN_NS = 500;
  localparam int CONV_MAX_NS = 2000;
  localparam int CONV_MIN_CYCLES = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYCLES = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int DATA_BITS = 16;
  localparam int SYNC_STAGES = 2;
  localparam logic [4:0] FALLS_PLAIN = 5'h10;
  localparam logic [4:0] FALLS_BUSY = 5'h11;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  // Pin synchroniser value after reset: convert low, select high, serial clock low.
  localparam logic [2:0] PIN_RESET = 3'h2;
endpackage

// >>> rtl/acr_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ns
`default_nettype none
module acr_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import acr_pkg::*;
  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_width_range
    $error("WIDTH out of range");
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/acr_readout.sv
// Chip-select conversion and serial readout logic of the converter.
`timescale 1ns/1ns
`default_nettype none
module acr_readout #(
  parameter int CONV_CYCLES = acr_pkg::CONV_MAX_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic convert_line,
  input wire logic select_input,
  input wire logic serial_clock,
  input wire logic [acr_pkg::DATA_BITS-1:0] sample_data,
  output logic serial_output,
  output logic serial_output_oe_n,
  output logic acquiring
);
  import acr_pkg::*;

  // The conversion timer is 16 bits wide and needs at least two cycles to count.
  if (CONV_CYCLES < 2 || CONV_CYCLES > 65535) begin : g_conv_range
    $error("CONV_CYCLES out of range");
  end

  typedef enum logic [1:0] {S_IDLE, S_CONV, S_READY, S_SHIFT} acr_phase_t;

  typedef struct packed {
    acr_phase_t phase;
    logic prev_convert;
    logic prev_sck;
    logic [15:0] timer;
    logic [4:0] falls;
    logic busy;
    logic [DATA_BITS-1:0] data;
    logic bit_out;
    logic oe_n;
    logic acq;
  } acr_state_t;

  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

  logic [2:0] pins;
  logic convert;
  logic sel;
  logic sck;
  logic start;
  logic sel_on;
  logic sck_fall;
  logic [4:0] total;
  acr_state_t st;
  acr_state_t next_st;

  // Resetting the select stage high keeps reset from looking like a both-low request.
  acr_sync #(.WIDTH(3), .RESET_VALUE(PIN_RESET)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({convert_line, select_input, serial_clock}),
    .sync_out(pins)
  );

  assign convert = pins[2];
  assign sel = pins[1];
  assign sck = pins[0];

  // Bit on the wire after k falling edges; busy mode spends edge zero on the low marker.
  function automatic logic bit_at(input logic [DATA_BITS-1:0] d, input logic b,
                                  input logic [4:0] k);
    logic r;
    r = 1'b0;
    if (b) begin
      if (k != 5'h00) begin
        r = d[4'(5'h10 - k)];
      end
    end else begin
      r = d[4'(5'h0F - k)];
    end
    return r;
  endfunction

  always_comb begin
    // Either low selects: convert in 3-wire use, select input in 4-wire use.
    sel_on = !convert || !sel;
    sck_fall = st.prev_sck && !sck;
    start = convert && !st.prev_convert && sel && st.phase != S_CONV;
    total = st.busy ? FALLS_BUSY : FALLS_PLAIN;
  end

  always_comb begin
    next_st = st;
    next_st.prev_convert = convert;
    next_st.prev_sck = sck;
    case (st.phase)
      S_IDLE: begin
        next_st.bit_out = 1'b0;
        next_st.oe_n = !(!convert && !sel);
      end
      S_CONV: begin
        next_st.timer = st.timer + 16'h0001;
        if (st.timer == CONV_LAST) begin
          next_st.acq = 1'b1;
          next_st.timer = TIMER_RESET;
          next_st.falls = 5'h00;
          if (sel_on) begin
            next_st.busy = 1'b1;
            next_st.phase = S_SHIFT;
            next_st.bit_out = 1'b0;
            next_st.oe_n = 1'b0;
          end else begin
            next_st.busy = 1'b0;
            next_st.phase = S_READY;
          end
        end
      end
      S_READY: begin
        if (sel_on) begin
          next_st.phase = S_SHIFT;
          next_st.falls = 5'h00;
          next_st.bit_out = st.data[DATA_BITS-1];
          next_st.oe_n = 1'b0;
        end
      end
      S_SHIFT: begin
        if (!sel_on) begin
          next_st.phase = S_IDLE;
          next_st.oe_n = 1'b1;
        end else if (sck_fall) begin
          if (st.falls + 5'h01 == total) begin
            next_st.phase = S_IDLE;
            next_st.oe_n = 1'b1;
          end else begin
            next_st.falls = st.falls + 5'h01;
            next_st.bit_out = bit_at(st.data, st.busy, st.falls + 5'h01);
          end
        end
      end
      default: begin
        next_st.phase = S_IDLE;
        next_st.oe_n = 1'b1;
      end
    endcase
    if (start) begin
      next_st.phase = S_CONV;
      next_st.timer = TIMER_RESET;
      next_st.data = sample_data;
      next_st.oe_n = 1'b1;
      next_st.acq = 1'b0;
    end
  end

  // Sampling only on the system clock keeps the output steady between falling edges.
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '{phase: S_IDLE, prev_convert: 1'b0, prev_sck: 1'b0, timer: TIMER_RESET,
              falls: 5'h00, busy: 1'b0, data: '0, bit_out: 1'b0, oe_n: 1'b1, acq: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign serial_output = st.bit_out;
  assign serial_output_oe_n = st.oe_n;
  assign acquiring = st.acq;

  start_floats_a: assert property (@(posedge clock) disable iff (rst)
    start |=> (st.phase == S_CONV && st.oe_n && !st.acq))
    else $error("conversion start did not float the output");

  conv_runs_a: assert property (@(posedge clock) disable iff (rst)
    (st.phase == S_CONV && st.timer != CONV_LAST) |=> st.phase == S_CONV)
    else $error("conversion ended early");

  conv_end_acq_a: assert property (@(posedge clock) disable iff (rst)
    (st.phase == S_CONV && st.timer == CONV_LAST && !start) |=> st.acq && st.phase != S_CONV)
    else $error("no acquisition after conversion");

  conv_hiz_a: assert property (@(posedge clock) disable iff (rst)
    st.phase == S_CONV |-> st.oe_n)
    else $error("output driven during conversion");

  busy_low_a: assert property (@(posedge clock) disable iff (rst)
    (st.phase == S_CONV && st.timer == CONV_LAST && sel_on) |=> (!st.oe_n && !st.bit_out))
    else $error("busy marker not driven low");

  msb_first_a: assert property (@(posedge clock) disable iff (rst)
    (st.phase == S_READY && sel_on && !start) |=> (!st.oe_n && st.bit_out == st.data[15]))
    else $error("msb not presented on select");

  shift_step_a: assert property (@(posedge clock) disable iff (rst)
    (st.phase == S_SHIFT && sel_on && sck_fall && !start && st.falls + 5'h01 != total)
    |=> (st.falls == $past(st.falls) + 5'h01 && !st.oe_n))
    else $error("falling edge did not advance the bit");

  bit_hold_a: assert property (@(posedge clock) disable iff (rst)
    (st.phase == S_SHIFT && sel_on && !sck_fall && !start) |=> $stable(st.bit_out))
    else $error("output bit changed between falling edges");

  deselect_float_a: assert property (@(posedge clock) disable iff (rst)
    (st.phase == S_SHIFT && !sel_on && !start) |=> ##[0:1] st.oe_n)
    else $error("output not released on deselect");

  count_float_a: assert property (@(posedge clock) disable iff (rst)
    (st.phase == S_SHIFT && sel_on && sck_fall && !start && st.falls + 5'h01 == total)
    |=> (st.oe_n && st.phase == S_IDLE))
    else $error("output not released after last edge");

  both_low_a: assert property (@(posedge clock) disable iff (rst)
    (st.phase == S_IDLE && !convert && !sel) |=> (!st.oe_n && !st.bit_out))
    else $error("output not driven low with both lines low");

  ready_float_a: assert property (@(posedge clock) disable iff (rst)
    st.phase == S_READY |-> st.oe_n)
    else $error("output driven before the part was selected");

  acq_hold_a: assert property (@(posedge clock) disable iff (rst)
    (st.acq && !start) |=> st.acq)
    else $error("acquisition left without a conversion start");

  idle_low_a: assert property (@(posedge clock) disable iff (rst)
    (st.phase == S_IDLE && !st.oe_n) |-> !st.bit_out)
    else $error("idle output driven with a data bit");

  sample_hold_a: assert property (@(posedge clock) disable iff (rst)
    start |=> st.data == $past(sample_data))
    else $error("conversion start did not capture the sample");
endmodule
`default_nettype wire

// >>> verif/acr_host.sv
// Host controller model that drives the converter pins and reads the pulled-up data line.
`timescale 1ns/1ns
`default_nettype none
module acr_host (
  input wire logic clock,
  input wire logic serial_output,
  input wire logic serial_output_oe_n,
  output logic convert_line,
  output logic select_input,
  output logic serial_clock,
  output wire logic data_pin
);
  // A released line reads high through the pull-up, so the busy marker shows as a fall.
  // Only one converter sits on this line, so there is never any contention on it.
  assign data_pin = serial_output_oe_n ? 1'h1 : serial_output;
  initial begin
    convert_line = 1'h0;
    select_input = 1'h1;
    serial_clock = 1'h0;
  end
  // Scenarios pick levels that keep the line steady from before the minimum time to the end.
  task automatic pins(input logic conv, input logic sel);
    @(posedge clock);
    convert_line <= conv;
    select_input <= sel;
  endtask
  // Select is high at the convert rise so that a conversion starts.
  task automatic start();
    pins(1'h1, 1'h1);
  endtask
  // Half a serial-clock period of 80 ns; the clock stands still between frames.
  task automatic sck_half(input logic level);
    @(posedge clock);
    serial_clock <= level;
    repeat (7) @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking testbench for the chip-select readout block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int CONV = 20;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [15:0] sample_data = 16'h0000;
  logic convert_line, select_input, serial_clock, serial_output, serial_output_oe_n, acquiring;
  wire logic data_pin;
  int fail_count = 0;
  int n_compared = 0;
  time t_up = 0;
  time t_dn = 0;
  always #5 clock = ~clock;
  always @(posedge acquiring) t_up = $time;
  always @(negedge acquiring) t_dn = $time;
  acr_readout #(.CONV_CYCLES(CONV)) acr_readout_inst (.clock(clock), .rst(rst),
    .convert_line(convert_line), .select_input(select_input), .serial_clock(serial_clock),
    .sample_data(sample_data), .serial_output(serial_output),
    .serial_output_oe_n(serial_output_oe_n), .acquiring(acquiring));
  acr_host acr_host_inst (.clock(clock), .serial_output(serial_output),
    .serial_output_oe_n(serial_output_oe_n), .convert_line(convert_line),
    .select_input(select_input), .serial_clock(serial_clock), .data_pin(data_pin));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic check_bit(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One conversion and readout; mid levels select early, hold levels decide busy.
  task automatic frame(input logic [15:0] word, input logic mid_conv, input logic mid_sel,
                       input logic hold_conv, input logic hold_sel, input logic busy,
                       input int nbits);
    int n;
    acr_host_inst.pins(1'h0, 1'h1);
    settle(4);
    acr_host_inst.start();
    sample_data <= word;
    // The start reaches the core three edges after the pin; change the word only then.
    repeat (3) @(posedge clock);
    sample_data <= ~word;
    settle(1);
    check_bit(serial_output_oe_n, 1'h1);
    check_bit(acquiring, 1'h0);
    acr_host_inst.pins(mid_conv, mid_sel);
    settle(3);
    check_bit(data_pin, 1'h1);
    acr_host_inst.pins(hold_conv, hold_sel);
    for (n = 0; n < 200 && acquiring !== 1'h1; n++) settle(1);
    if (n == 200) begin
      fail_count++;
      tally_and_finish();
    end
    settle(1);
    check(16'((t_up - t_dn) / 10), 16'(CONV));
    check_bit(acquiring, 1'h1);
    check_bit(serial_output_oe_n, ~busy);
    if (busy) begin
      check_bit(data_pin, 1'h0);
      acr_host_inst.sck_half(1'h1);
      acr_host_inst.sck_half(1'h0);
    end else begin
      acr_host_inst.pins(mid_conv, mid_sel);
      settle(4);
    end
    for (int i = 15; i > 15 - nbits; i--) begin
      check_bit(data_pin, word[i]);
      acr_host_inst.sck_half(1'h1);
      check_bit(data_pin, word[i]);
      acr_host_inst.sck_half(1'h0);
    end
    if (nbits == 16) check_bit(serial_output_oe_n, 1'h1);
    acr_host_inst.pins(1'h1, 1'h1);
    settle(4);
    check_bit(serial_output_oe_n, 1'h1);
    settle(CONV + 8);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    settle(1);
    check_bit(serial_output_oe_n, 1'h1);
    check_bit(acquiring, 1'h1);
    acr_host_inst.pins(1'h0, 1'h0);
    settle(4);
    check_bit(data_pin, 1'h0);
    check_bit(serial_output_oe_n, 1'h0);
    frame(16'hA5C3, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 16);
    frame(16'h3C5A, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 16);
    frame(16'h8001, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 16);
    frame(16'h7FFE, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 16);
    frame(16'hF00F, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 5);
    frame(16'h0FF0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
